// [motion_command_validator.sv]
// Purpose: Two-axis command validator with an Avalon-MM register slave.
// Assumes: 10 MHz clk, asynchronous active-low resetn, 32-bit bus.
// Notes: Writes to the command register start a two-cycle evaluation.
// Summary of operation
// [RULE1] Middle-point: same start and end, 285
// [RULE2] Radius outside 1..2147483647 gives 286
// [RULE3] Middle-point collinear with ends gives 287
// [RULE4] Angular step above 90 degrees gives 290
// [RULE5] Simultaneous start, axis running, gives 291
// [RULE6] Simultaneous start, output inhibited, gives 292
// [RULE7] Simultaneous start, aux flag set, 293
// [RULE8] Aux clear command drops aux flag
// [RULE9] Synchronous start without travel gives 294
// [RULE10] Simultaneous start needs both axes, else 296
// [RULE11] Speed-to-position on stopped axis gives 301
// [RULE12] Speed-to-position outside speed control gives 302
// [RULE13] Speed-to-position on sync follower gives 303
// [RULE14] Speed-to-position with zero goal gives 304
// [RULE15] Position-to-speed on stopped axis gives 311
// [RULE16] Position-to-speed on sync follower gives 312
// [RULE17] Position-to-speed during circular gives 313
// [RULE18] Position-to-speed during linear gives 314
// [RULE19] Position-to-speed in deceleration gives 316
// [RULE20] Position-to-speed needs positioning or inching, 317
// [RULE21] Absolute move without origin is rejected
// [RULE22] Rejection keeps motion, latches axis error
// [RULE23] One error per command, fixed priority
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module motion_command_validator
  import mcv_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic avs_response_err,
  input wire logic [1:0] stop_in,
  input wire logic [3:0] sec_in,
  output logic [1:0] axis_run,
  output logic cmd_done
);
  // Parameter registers
  logic [31:0] cmd_reg;
  logic [1:0] sel_reg;
  logic [31:0] goal_reg [AXES];
  logic [31:0] radius_reg;
  logic [31:0] angvel_reg;
  logic [6:0] geom_reg;
  logic [15:0] err_reg [AXES]; // Latched error per axis
  logic [15:0] result_reg; // Code of the last command
  logic busy_reg; // Evaluation in progress
  logic eval_reg; // Second cycle: apply result
  logic ack_reg; // Bus answer cycle
  logic [31:0] rdata_reg;
  logic rerr_reg;
  logic [1:0] run_out_reg;
  logic done_reg;
  logic [15:0] err_code; // From checker
  // Axis state carriers
  axis_if ax_bus ();
  axis_if ay_bus ();
  // Decoded command fields
  wire op_t cur_op = op_t'(cmd_reg[CMD_OP_LSB +: 4]);
  wire logic cur_axis = cmd_reg[CMD_AXIS_BIT];
  wire logic is_wr = avs_write && !ack_reg;
  wire logic is_rd = avs_read && !ack_reg;
  wire logic hit_cmd = is_wr && (avs_address == OFF_CMD) && !busy_reg;
  wire logic hit_ctl = is_wr && (avs_address == OFF_AXCTL);
  wire logic wr_stall = is_wr && (avs_address == OFF_CMD) && busy_reg;
  wire logic accepted = eval_reg && (err_code == E_NONE);
  wire logic rejected = eval_reg && (err_code != E_NONE);
  wire logic [31:0] goal_cur = goal_reg[cur_axis];
  wire logic aux_cmd = accepted && (cur_op == OP_AUXCLR);
  wire logic motion_op = (cur_op == OP_CIRC) || (cur_op == OP_SIM) ||
                         (cur_op == OP_SYNC) || (cur_op == OP_POS) ||
                         (cur_op == OP_LIN) || (cur_op == OP_SPEED) ||
                         (cur_op == OP_INCH);
  wire logic both_ax = (cur_op == OP_CIRC) || (cur_op == OP_SIM);
  wire logic known_addr = (avs_address[1:0] == 2'b00) &&
                          (avs_address <= OFF_RESULT);
  // Start mode chosen from the command kind
  mode_t start_mode;
  always_comb begin
    start_mode = MODE_POS;
    unique case (cur_op)
      OP_CIRC: start_mode = MODE_CIRC;
      OP_SYNC: start_mode = MODE_FOLL; // Sync start runs as a follower
      OP_LIN: start_mode = MODE_LIN;
      OP_SPEED: start_mode = MODE_SPEED;
      OP_INCH: start_mode = MODE_INCH;
      default: start_mode = MODE_POS;
    endcase
  end
  // Per-axis control strobes, one generate lane each
  logic [AXES-1:0] start_v;
  logic [AXES-1:0] to_spd_v;
  logic [AXES-1:0] to_pos_v;
  logic [AXES-1:0] ctl_lane;
  logic [31:0] st_word [AXES];
  genvar g;
  generate
    for (g = 0; g < AXES; g++) begin : g_lane
      wire logic mine = (cur_axis == 1'(g));
      // Rejected commands never assert start, so motion is untouched
      assign start_v[g] = accepted && motion_op &&
                          (both_ax || mine); // [RULE22]
      assign to_spd_v[g] = accepted && (cur_op == OP_PS) && mine;
      assign to_pos_v[g] = accepted && (cur_op == OP_SP) && mine;
      assign ctl_lane[g] = hit_ctl && avs_byteenable[g];
    end
  endgenerate
  wire logic [7:0] ctl_x = avs_writedata[7:0];
  wire logic [7:0] ctl_y = avs_writedata[15:8];
  // Axis X tracker
  axis_state u_ax (
    .clk(clk),
    .resetn(resetn),
    .start(start_v[0]),
    .start_mode(start_mode),
    .to_speed(to_spd_v[0]),
    .to_pos(to_pos_v[0]),
    .aux_set(ctl_lane[0] && ctl_x[CTL_SET_AUX]),
    .aux_clr(aux_cmd && !cur_axis), // [RULE8]
    .inh_set(ctl_lane[0] && ctl_x[CTL_SET_INH]),
    .inh_clr(ctl_lane[0] && ctl_x[CTL_CLR_INH]),
    .org_set(ctl_lane[0] && ctl_x[CTL_SET_ORG]),
    .stop(stop_in[0] || (ctl_lane[0] && ctl_x[CTL_STOP])),
    .sec_in(sec_t'(sec_in[1:0])),
    .st(ax_bus.tracker)
  );
  // Axis Y tracker
  axis_state u_ay (
    .clk(clk),
    .resetn(resetn),
    .start(start_v[1]),
    .start_mode(start_mode),
    .to_speed(to_spd_v[1]),
    .to_pos(to_pos_v[1]),
    .aux_set(ctl_lane[1] && ctl_y[CTL_SET_AUX]),
    .aux_clr(aux_cmd && cur_axis), // [RULE8]
    .inh_set(ctl_lane[1] && ctl_y[CTL_SET_INH]),
    .inh_clr(ctl_lane[1] && ctl_y[CTL_CLR_INH]),
    .org_set(ctl_lane[1] && ctl_y[CTL_SET_ORG]),
    .stop(stop_in[1] || (ctl_lane[1] && ctl_y[CTL_STOP])),
    .sec_in(sec_t'(sec_in[3:2])),
    .st(ay_bus.tracker)
  );
  // Priority checker
  cmd_check u_chk (
    .op(cur_op),
    .axis(cur_axis),
    .sel(sel_reg),
    .goal(goal_cur),
    .radius(radius_reg),
    .angvel(angvel_reg),
    .geom(geom_reg),
    .ax(ax_bus.reader),
    .ay(ay_bus.reader),
    .err(err_code) // [RULE23]
  );
  // Status words for readback
  assign st_word[0] = {22'h0, 2'(ax_bus.sec), 1'b0, 3'(ax_bus.mode),
                       ax_bus.org, ax_bus.aux, ax_bus.inh, ax_bus.run};
  assign st_word[1] = {22'h0, 2'(ay_bus.sec), 1'b0, 3'(ay_bus.mode),
                       ay_bus.org, ay_bus.aux, ay_bus.inh, ay_bus.run};
  // Read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = RESET_VAL;
    unique case (avs_address)
      OFF_CMD: rd_mux = cmd_reg;
      OFF_SEL: rd_mux = {30'h0, sel_reg};
      OFF_GOAL_X: rd_mux = goal_reg[0];
      OFF_GOAL_Y: rd_mux = goal_reg[1];
      OFF_RADIUS: rd_mux = radius_reg;
      OFF_ANGVEL: rd_mux = angvel_reg;
      OFF_GEOM: rd_mux = {25'h0, geom_reg};
      OFF_ERR_X: rd_mux = {16'h0, err_reg[0]};
      OFF_ERR_Y: rd_mux = {16'h0, err_reg[1]};
      OFF_STAT_X: rd_mux = st_word[0];
      OFF_STAT_Y: rd_mux = st_word[1];
      OFF_RESULT: rd_mux = {15'h0, busy_reg, result_reg};
      default: rd_mux = RESET_VAL;
    endcase
  end
  // Bus answer: one wait cycle, then ack; command writes stall while busy
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
      rdata_reg <= RESET_VAL;
      rerr_reg <= 1'b0;
    end else begin
      ack_reg <= (is_rd || is_wr) && !wr_stall;
      if (is_rd) begin
        rdata_reg <= rd_mux;
      end
      if ((is_rd || is_wr) && !wr_stall) begin
        rerr_reg <= !known_addr;
      end
    end
  end
  // Parameter register writes, taken in the request cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_reg <= 2'b00;
      goal_reg[0] <= RESET_VAL;
      goal_reg[1] <= RESET_VAL;
      radius_reg <= RESET_VAL;
      angvel_reg <= RESET_VAL;
      geom_reg <= 7'h00;
    end else if (is_wr) begin
      unique case (avs_address)
        OFF_SEL: sel_reg <= avs_writedata[1:0]; // [RULE10]
        OFF_GOAL_X: goal_reg[0] <= avs_writedata;
        OFF_GOAL_Y: goal_reg[1] <= avs_writedata;
        OFF_RADIUS: radius_reg <= avs_writedata;
        OFF_ANGVEL: angvel_reg <= avs_writedata;
        OFF_GEOM: geom_reg <= avs_writedata[6:0];
        default: ;
      endcase
    end
  end
  // Command sequencing: write, evaluate, apply
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_reg <= RESET_VAL;
      busy_reg <= 1'b0;
      eval_reg <= 1'b0;
    end else begin
      if (hit_cmd) begin
        cmd_reg <= avs_writedata;
        busy_reg <= 1'b1;
      end else if (eval_reg) begin
        busy_reg <= 1'b0;
      end
      eval_reg <= busy_reg && !eval_reg;
    end
  end
  // Error latching for the commanded axis, or both for paired commands
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      err_reg[0] <= E_NONE;
      err_reg[1] <= E_NONE;
      result_reg <= E_NONE;
    end else if (eval_reg) begin
      result_reg <= err_code; // [RULE23]
      if (rejected && (both_ax || !cur_axis)) begin
        err_reg[0] <= err_code; // [RULE22]
      end
      if (rejected && (both_ax || cur_axis)) begin
        err_reg[1] <= err_code; // [RULE22]
      end
    end
  end
  // Registered outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_out_reg <= 2'b00;
      done_reg <= 1'b0;
    end else begin
      run_out_reg <= {ay_bus.run, ax_bus.run};
      done_reg <= eval_reg;
    end
  end
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = !ack_reg;
  assign avs_response_err = rerr_reg;
  assign axis_run = run_out_reg;
  assign cmd_done = done_reg;
endmodule : motion_command_validator
`default_nettype wire

// [mcv_pkg.sv]
// Purpose: Shared constants and types for the motion command validator.
// Assumes: Avalon-MM slave with 32-bit data, word addressed by byte offset.
// Notes: Error codes are the decimal numbers reported to software.
package mcv_pkg;
  localparam int unsigned AXES = 2;
  // Register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_SEL = 8'h04;
  localparam logic [7:0] OFF_GOAL_X = 8'h08;
  localparam logic [7:0] OFF_GOAL_Y = 8'h0c;
  localparam logic [7:0] OFF_RADIUS = 8'h10;
  localparam logic [7:0] OFF_ANGVEL = 8'h14;
  localparam logic [7:0] OFF_GEOM = 8'h18;
  localparam logic [7:0] OFF_AXCTL = 8'h1c;
  localparam logic [7:0] OFF_ERR_X = 8'h20;
  localparam logic [7:0] OFF_ERR_Y = 8'h24;
  localparam logic [7:0] OFF_STAT_X = 8'h28;
  localparam logic [7:0] OFF_STAT_Y = 8'h2c;
  localparam logic [7:0] OFF_RESULT = 8'h30;
  // Command register fields
  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_AXIS_BIT = 4;
  // Geometry flag fields
  localparam int unsigned GEOM_MIDMODE = 0;
  localparam int unsigned GEOM_SAME_SE = 1;
  localparam int unsigned GEOM_COLLIN = 2;
  localparam int unsigned GEOM_ABS_X = 3;
  localparam int unsigned GEOM_ABS_Y = 4;
  localparam int unsigned GEOM_ATGOAL_X = 5;
  localparam int unsigned GEOM_ATGOAL_Y = 6;
  // Axis control write fields (per axis, byte lane = axis)
  localparam int unsigned CTL_SET_AUX = 0;
  localparam int unsigned CTL_SET_INH = 1;
  localparam int unsigned CTL_CLR_INH = 2;
  localparam int unsigned CTL_SET_ORG = 3;
  localparam int unsigned CTL_STOP = 4;
  localparam logic [31:0] RADIUS_MAX = 32'h7fffffff;
  localparam logic [31:0] ANGVEL_MAX = 32'h0000005a;
  localparam logic [31:0] RESET_VAL = 32'h00000000;
  // Error codes
  localparam logic [15:0] E_NONE = 16'h0000;
  localparam logic [15:0] E_ORIGIN = 16'h0115;
  localparam logic [15:0] E_SAME_SE = 16'h011d;
  localparam logic [15:0] E_RADIUS = 16'h011e;
  localparam logic [15:0] E_COLLIN = 16'h011f;
  localparam logic [15:0] E_ANGVEL = 16'h0122;
  localparam logic [15:0] E_SIM_RUN = 16'h0123;
  localparam logic [15:0] E_SIM_INH = 16'h0124;
  localparam logic [15:0] E_SIM_AUX = 16'h0125;
  localparam logic [15:0] E_SYN_GOAL = 16'h0126;
  localparam logic [15:0] E_SIM_SEL = 16'h0128;
  localparam logic [15:0] E_SP_STOP = 16'h012d;
  localparam logic [15:0] E_SP_MODE = 16'h012e;
  localparam logic [15:0] E_SP_FOLL = 16'h012f;
  localparam logic [15:0] E_SP_GOAL = 16'h0130;
  localparam logic [15:0] E_PS_STOP = 16'h0137;
  localparam logic [15:0] E_PS_FOLL = 16'h0138;
  localparam logic [15:0] E_PS_CIRC = 16'h0139;
  localparam logic [15:0] E_PS_LIN = 16'h013a;
  localparam logic [15:0] E_PS_DECEL = 16'h013c;
  localparam logic [15:0] E_PS_MODE = 16'h013d;
  // Commands
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_CIRC = 4'h1, OP_SIM = 4'h2, OP_SYNC = 4'h3,
    OP_SP = 4'h4, OP_PS = 4'h5, OP_AUXCLR = 4'h6, OP_POS = 4'h7,
    OP_SPEED = 4'h8, OP_LIN = 4'h9, OP_INCH = 4'ha
  } op_t;
  // Control modes of an axis
  typedef enum logic [2:0] {
    MODE_POS = 3'h0, MODE_SPEED = 3'h1, MODE_CIRC = 3'h2,
    MODE_LIN = 3'h3, MODE_INCH = 3'h4, MODE_FOLL = 3'h5
  } mode_t;
  // Profile sections
  typedef enum logic [1:0] {
    SEC_ACC = 2'h0, SEC_CONST = 2'h1, SEC_DEC = 2'h2
  } sec_t;
  // Per-axis status word layout
  localparam int unsigned ST_RUN = 0;
  localparam int unsigned ST_INH = 1;
  localparam int unsigned ST_AUX = 2;
  localparam int unsigned ST_ORG = 3;
  localparam int unsigned ST_MODE_LSB = 4;
  localparam int unsigned ST_SEC_LSB = 8;
endpackage : mcv_pkg

// [axis_if.sv]
// Purpose: Carries one axis's state from the axis tracker to the checker.
// Assumes: Single clock domain.
// Notes: Tracker drives, checker reads.
`timescale 1ns/1ps
`default_nettype none
interface axis_if;
  import mcv_pkg::*;
  logic run; // Axis is moving
  logic inh; // Output inhibit
  logic aux; // Auxiliary code flag
  logic org; // Origin established
  mode_t mode; // Control mode
  sec_t sec; // Profile section
  modport tracker (output run, inh, aux, org, mode, sec);
  modport reader (input run, inh, aux, org, mode, sec);
endinterface : axis_if
`default_nettype wire

// [axis_state.sv]
// Purpose: Holds one axis's run state, mode, flags and profile section.
// Assumes: Start and control pulses are one cycle wide.
// Notes: A rejected command never reaches start, so state is kept.
`timescale 1ns/1ps
`default_nettype none
module axis_state
  import mcv_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire mode_t start_mode,
  input wire logic to_speed,
  input wire logic to_pos,
  input wire logic aux_set,
  input wire logic aux_clr,
  input wire logic inh_set,
  input wire logic inh_clr,
  input wire logic org_set,
  input wire logic stop,
  input wire sec_t sec_in,
  axis_if.tracker st
);
  logic run_reg;
  logic inh_reg;
  logic aux_reg;
  logic org_reg;
  mode_t mode_reg;
  sec_t sec_reg;
  // Flag and motion state; set wins over clear for the aux flag
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_reg <= 1'b0;
      inh_reg <= 1'b0;
      aux_reg <= 1'b0;
      org_reg <= 1'b0;
      mode_reg <= MODE_POS;
      sec_reg <= SEC_ACC;
    end else begin
      if (start) begin
        run_reg <= 1'b1;
        mode_reg <= start_mode;
      end else if (stop) begin
        run_reg <= 1'b0;
      end
      if (to_speed) begin
        mode_reg <= MODE_SPEED;
      end else if (to_pos) begin
        mode_reg <= MODE_POS;
      end
      if (aux_set) begin
        aux_reg <= 1'b1;
      end else if (aux_clr) begin
        aux_reg <= 1'b0; // [RULE8]
      end
      if (inh_set) begin
        inh_reg <= 1'b1;
      end else if (inh_clr) begin
        inh_reg <= 1'b0;
      end
      if (org_set) begin
        org_reg <= 1'b1;
      end
      sec_reg <= sec_in;
    end
  end
  assign st.run = run_reg;
  assign st.inh = inh_reg;
  assign st.aux = aux_reg;
  assign st.org = org_reg;
  assign st.mode = mode_reg;
  assign st.sec = sec_reg;
endmodule : axis_state
`default_nettype wire

// [cmd_check.sv]
// Purpose: Picks the one error code a command earns, by fixed priority.
// Assumes: Inputs are stable during the evaluation cycle.
// Notes: Purely combinational; the top registers the result.
`timescale 1ns/1ps
`default_nettype none
module cmd_check
  import mcv_pkg::*;
(
  input wire op_t op,
  input wire logic axis,
  input wire logic [1:0] sel,
  input wire logic [31:0] goal,
  input wire logic [31:0] radius,
  input wire logic [31:0] angvel,
  input wire logic [6:0] geom,
  axis_if.reader ax,
  axis_if.reader ay,
  output logic [15:0] err
);
  logic [1:0] run_v;
  logic [1:0] inh_v;
  logic [1:0] aux_v;
  logic [1:0] org_v;
  assign run_v = {ay.run, ax.run};
  assign inh_v = {ay.inh, ax.inh};
  assign aux_v = {ay.aux, ax.aux};
  assign org_v = {ay.org, ax.org};
  wire logic t_run = run_v[axis];
  wire mode_t t_mode = axis ? ay.mode : ax.mode;
  wire sec_t t_sec = axis ? ay.sec : ax.sec;
  wire logic abs_t = axis ? geom[GEOM_ABS_Y] : geom[GEOM_ABS_X];
  wire logic atgoal_t = axis ? geom[GEOM_ATGOAL_Y] : geom[GEOM_ATGOAL_X];
  wire logic abs_noorg = (geom[GEOM_ABS_X] && !org_v[0]) ||
                         (geom[GEOM_ABS_Y] && !org_v[1]);
  wire logic rad_bad = (radius == 32'h0) || (radius > RADIUS_MAX);
  // Priority chain: earliest test wins, one code per command
  always_comb begin
    err = E_NONE;
    unique case (op)
      OP_CIRC: begin
        if (abs_noorg) err = E_ORIGIN; // [RULE21] [RULE23]
        else if (geom[GEOM_MIDMODE] && geom[GEOM_SAME_SE])
          err = E_SAME_SE; // [RULE1]
        else if (!geom[GEOM_MIDMODE] && rad_bad) err = E_RADIUS; // [RULE2]
        else if (geom[GEOM_MIDMODE] && geom[GEOM_COLLIN])
          err = E_COLLIN; // [RULE3]
        else if (angvel > ANGVEL_MAX) err = E_ANGVEL; // [RULE4]
      end
      OP_SIM: begin
        if (sel != 2'b11) err = E_SIM_SEL; // [RULE10]
        else if (|run_v) err = E_SIM_RUN; // [RULE5]
        else if (|inh_v) err = E_SIM_INH; // [RULE6]
        else if (|aux_v) err = E_SIM_AUX; // [RULE7]
        else if (abs_noorg) err = E_ORIGIN; // [RULE21]
      end
      OP_SYNC: begin
        if (abs_t && !org_v[axis]) err = E_ORIGIN; // [RULE21]
        else if (abs_t ? atgoal_t : (goal == 32'h0))
          err = E_SYN_GOAL; // [RULE9]
      end
      OP_SP: begin
        if (!t_run) err = E_SP_STOP; // [RULE11]
        else if (t_mode == MODE_FOLL) err = E_SP_FOLL; // [RULE13]
        else if (t_mode != MODE_SPEED) err = E_SP_MODE; // [RULE12]
        else if (goal == 32'h0) err = E_SP_GOAL; // [RULE14]
      end
      OP_PS: begin
        if (!t_run) err = E_PS_STOP; // [RULE15]
        else if (t_mode == MODE_FOLL) err = E_PS_FOLL; // [RULE16]
        else if (t_mode == MODE_CIRC) err = E_PS_CIRC; // [RULE17]
        else if (t_mode == MODE_LIN) err = E_PS_LIN; // [RULE18]
        else if (t_mode != MODE_POS && t_mode != MODE_INCH)
          err = E_PS_MODE; // [RULE20]
        else if (t_sec == SEC_DEC) err = E_PS_DECEL; // [RULE19]
      end
      OP_POS, OP_LIN: begin
        if (abs_t && !org_v[axis]) err = E_ORIGIN; // [RULE21]
      end
      default: err = E_NONE;
    endcase
  end
endmodule : cmd_check
`default_nettype wire

// [mcv_checker_assertions.sv]
// Purpose: Port-level timing checks of the command validator.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound to the top module after the checker.
`timescale 1ns/1ps
`default_nettype none
module mcv_checker
  import mcv_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic avs_response_err,
  input wire logic [1:0] stop_in,
  input wire logic [1:0] axis_run,
  input wire logic cmd_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire cmd_wr = avs_write && avs_address == OFF_CMD; // Command write
  wire cmd_ack = cmd_wr && !avs_waitrequest; // Command accepted
  // Plain accesses wait one cycle at most; only commands may wait on busy
  chk_reg_ack: assert property ((avs_read || (avs_write && !cmd_wr))
    && avs_waitrequest |=> !avs_waitrequest) else $error("late ack");
  chk_ack_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("ack held");
  chk_cmd_stall: assert property (cmd_wr |-> ##[0:4] !avs_waitrequest)
    else $error("command stall too long");
  chk_cmd_done: assert property (cmd_ack |-> ##[1:3] cmd_done)
    else $error("no done pulse");
  chk_done_pulse: assert property (cmd_done |=> !cmd_done)
    else $error("done too wide");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest
    && avs_response_err |-> avs_readdata == 32'h0) else $error("bad data");
  // Motion only starts as the result of an accepted command
  chk_run_cause: assert property (
    $rose(axis_run[0]) || $rose(axis_run[1])
    |-> $past(cmd_ack, 2) || $past(cmd_ack, 3) || $past(cmd_ack, 4))
    else $error("run without command");
  chk_stop_fall: assert property ($fell(axis_run[0]) |-> $past(stop_in[0])
    || $past(stop_in[0], 2) || $past(stop_in[0], 3))
    else $error("run dropped without stop");
  cov_done: cover property (cmd_done);
  cov_run: cover property ($rose(axis_run[1]));
  cov_unmapped: cover property (avs_response_err && !avs_waitrequest);
endmodule : mcv_checker
bind motion_command_validator mcv_checker u_mon (.clk(clk), .resetn(resetn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response_err(avs_response_err), .stop_in(stop_in),
  .axis_run(axis_run), .cmd_done(cmd_done));
`default_nettype wire

// [host_model.sv]
// Purpose: Host bus master issuing register accesses.
// Assumes: Avalon-MM slave with waitrequest.
// Notes: Released lines carry an inverted pattern.
`timescale 1ns/1ps
`default_nettype none
module host_model
  import mcv_pkg::*;
(
  input wire logic clk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_response_err,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable
);
  // Idle bus at time zero
  initial begin
    avs_address = 8'hff;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
  end
  // One transfer, held until waitrequest is sampled low
  task automatic xfer(input logic rd, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] be,
      output logic [31:0] q, output logic e, output logic ok);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= d;
    avs_byteenable <= be;
    ok = 1'b0;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge clk);
      ok = (avs_waitrequest === 1'b0);
    end
    q = avs_readdata;
    e = avs_response_err;
    // Stale values would hide a slave sampling too late
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask : xfer
endmodule : host_model
`default_nettype wire

// [test_motion_command_validator.sv]
// Purpose: Self-checking bench for the command validator.
// Assumes: Host model speaks the register bus.
// Notes: Rows cover stopped-axis and circular checks.
`timescale 1ns/1ps
`default_nettype none
module test_motion_command_validator
  import mcv_pkg::*;
;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [15:0] e;} row_t;
  logic clk, resetn, wreq, rreq, waitreq, rerr, done, ok, e;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [3:0] be;
  logic [1:0] stop_in, axis_run;
  logic [3:0] sec_in;
  int n_fail = 0;
  int cmp_count = 0;
  row_t rows [23] = '{
    '{OFF_SEL, 1, 0}, '{OFF_CMD, 2, E_SIM_SEL},
    '{OFF_CMD, 4, E_SP_STOP}, '{OFF_CMD, 5, E_PS_STOP},
    '{OFF_CMD, 3, E_SYN_GOAL}, '{OFF_GEOM, 32'h28, 0},
    '{OFF_CMD, 3, E_SYN_GOAL}, '{OFF_GEOM, 3, 0},
    '{OFF_CMD, 1, E_SAME_SE}, '{OFF_GEOM, 5, 0},
    '{OFF_CMD, 1, E_COLLIN}, '{OFF_GEOM, 0, 0},
    '{OFF_RADIUS, 0, 0}, '{OFF_CMD, 1, E_RADIUS},
    '{OFF_RADIUS, 32'h80000000, 0}, '{OFF_CMD, 1, E_RADIUS},
    '{OFF_RADIUS, 32'h7fffffff, 0}, '{OFF_ANGVEL, 32'h5b, 0},
    '{OFF_CMD, 1, E_ANGVEL}, '{OFF_ANGVEL, 32'h5a, 0},
    '{OFF_RADIUS, 1, 0}, '{OFF_CMD, 1, E_NONE},
    '{OFF_CMD, 5, E_PS_CIRC}};
  motion_command_validator u_dut (.clk(clk), .resetn(resetn),
    .avs_address(addr), .avs_read(rreq), .avs_write(wreq),
    .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(waitreq), .avs_response_err(rerr), .stop_in(stop_in),
    .sec_in(sec_in), .axis_run(axis_run), .cmd_done(done));
  host_model u_host (.clk(clk), .avs_waitrequest(waitreq),
    .avs_readdata(rdata), .avs_response_err(rerr), .avs_address(addr),
    .avs_read(rreq), .avs_write(wreq), .avs_writedata(wdata),
    .avs_byteenable(be));
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  task chk(input string nm, input logic [31:0] x, input logic [31:0] y);
    cmp_count++;
    if (y !== x) begin
      $display("[ERR] %s expected %h seen %h", nm, x, y);
      n_fail++;
    end
  endtask : chk
  // Bus access; a hung slave ends the run
  task xf(input logic r, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] b);
    u_host.xfer(r, a, d, b, q, e, ok);
    if (!ok) begin
      chk("bus timeout", 1, 0);
      stop_test();
    end
  endtask : xf
  // Issue a command, wait for done, compare the result code
  task cmd(input logic [7:0] c, input logic [15:0] x);
    int n;
    xf(0, OFF_CMD, {24'h0, c}, 4'hf);
    for (n = 0; n < 10 && done !== 1'b1; n++) @(negedge clk);
    if (done !== 1'b1) begin
      chk("cmd_done", 1, 0);
      stop_test();
    end
    xf(1, OFF_RESULT, 0, 4'hf);
    chk("result", {16'h0, x}, {16'h0, q[15:0]});
  endtask : cmd
  task halt(input logic [1:0] m);
    stop_in <= m;
    @(posedge clk);
    stop_in <= 2'b00;
    repeat (3) @(posedge clk);
  endtask : halt
  task run_is(input logic [1:0] x);
    @(negedge clk);
    chk("axis_run", {30'h0, x}, {30'h0, axis_run});
  endtask : run_is
  // Main sequence
  initial begin
    resetn = 1'b0;
    stop_in = 2'b00;
    sec_in = 4'h0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    xf(0, OFF_AXCTL, 32'h0808, 4'h3);
    foreach (rows[i]) begin
      if (rows[i].a == OFF_CMD) cmd(rows[i].d[7:0], rows[i].e);
      else xf(0, rows[i].a, rows[i].d, 4'hf);
    end
    halt(2'b11);
    run_is(2'b00);
    xf(0, OFF_GOAL_X, 5, 4'hf);
    cmd(OP_SPEED, E_NONE);
    run_is(2'b01);
    xf(0, OFF_SEL, 3, 4'hf);
    cmd(OP_SIM, E_SIM_RUN);
    cmd(OP_PS, E_PS_MODE);
    xf(0, OFF_GOAL_X, 0, 4'hf);
    cmd(OP_SP, E_SP_GOAL);
    xf(0, OFF_GOAL_X, 5, 4'hf);
    cmd(OP_SP, E_NONE);
    cmd(OP_SP, E_SP_MODE);
    sec_in <= 4'h2;
    cmd(OP_PS, E_PS_DECEL);
    sec_in <= 4'h1;
    cmd(OP_PS, E_NONE);
    halt(2'b01);
    cmd(8'h19, E_NONE);
    cmd(8'h15, E_PS_LIN);
    halt(2'b10);
    xf(0, OFF_AXCTL, 32'h0200, 4'h2);
    cmd(OP_SIM, E_SIM_INH);
    xf(0, OFF_AXCTL, 32'h0401, 4'h3);
    cmd(OP_SIM, E_SIM_AUX);
    run_is(2'b00);
    xf(1, OFF_ERR_Y, 0, 4'hf);
    chk("err_y", {16'h0, E_SIM_AUX}, q & 32'hffff);
    cmd(OP_AUXCLR, E_NONE);
    xf(1, OFF_STAT_X, 0, 4'hf);
    chk("aux", 0, q[ST_AUX]);
    cmd(OP_SIM, E_NONE);
    run_is(2'b11);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    xf(0, OFF_GEOM, 32'h08, 4'hf);
    cmd(OP_POS, E_ORIGIN);
    run_is(2'b00);
    xf(0, OFF_GOAL_Y, 7, 4'hf);
    cmd(8'h13, E_NONE);
    cmd(8'h14, E_SP_FOLL);
    cmd(8'h15, E_PS_FOLL);
    xf(1, 8'h40, 0, 4'hf);
    chk("unmapped", 32'h1, {q[30:0], e});
    stop_test();
  end
endmodule : test_motion_command_validator
`default_nettype wire
